/* rtl/chp_pkg.sv */
package chp_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int ROW_W = 8;

  localparam logic [7:0] OFF_ENH_CTL = 8'h00;
  localparam logic [7:0] OFF_PART_SPLIT = 8'h04;
  localparam logic [7:0] OFF_PTR_A = 8'h08;
  localparam logic [7:0] OFF_PTR_B = 8'h0c;
  localparam logic [7:0] OFF_LEN_A = 8'h10;
  localparam logic [7:0] OFF_LEN_B = 8'h14;
  localparam logic [7:0] OFF_LIVE_PTR_A = 8'h18;
  localparam logic [7:0] OFF_LIVE_PTR_B = 8'h1c;
  localparam logic [7:0] OFF_LIVE_LEN_A = 8'h20;
  localparam logic [7:0] OFF_LIVE_LEN_B = 8'h24;
  localparam logic [7:0] OFF_FA_STATUS = 8'h28;
  localparam logic [7:0] OFF_FA_MASK = 8'h2c;
  localparam logic [7:0] OFF_FA_IDENT = 8'h30;
  localparam logic [7:0] OFF_SURF_A = 8'h34;
  localparam logic [7:0] OFF_SURF_B = 8'h38;

  // Control bits
  localparam int CTL_CONTRAST_EN = 0;
  localparam int CTL_FAST_ACCESS = 1;
  localparam int CTL_APPLY_EN = 2;
  localparam int CTL_W = 3;

  // Part split fields
  localparam int PS_A_END_LSB = 8;
  localparam int PS_B_END_LSB = 24;

  // Status bit positions, part A then part B
  localparam int ST_HIST_READY = 0;
  localparam int ST_LOAD_TABLE = 2;
  localparam int ST_COPY_DONE = 4;
  localparam int ST_W = 6;
  localparam int ID_LATE = 6;
  localparam int ID_W = 7;

  localparam logic [CTL_W-1:0] CTL_RESET = 3'h0;
  localparam logic [ID_W-1:0] MASK_RESET = 7'h7f;
  localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;

  typedef enum logic {CHP_PART_A, CHP_PART_B} chp_part_t;
endpackage : chp_pkg

/* rtl/chp_part_handoff.sv */
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module chp_part_handoff (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [chp_pkg::ADDR_W-1:0] addr,
  input wire logic [chp_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [chp_pkg::DATA_W-1:0] rdata,
  input wire logic frame_start,
  input wire logic row_done,
  input wire logic table_load_done,
  output logic readout_start,
  output logic [chp_pkg::DATA_W-1:0] readout_ptr,
  output logic [chp_pkg::DATA_W-1:0] readout_len,
  output logic table_apply,
  output logic table_part,
  output logic active_part,
  output logic irq
);
  import chp_pkg::*;

  logic [CTL_W-1:0] ctl;
  logic [DATA_W-1:0] part_split, ptr_a, ptr_b, len_a, len_b;
  logic [DATA_W-1:0] live_split, live_ptr_a, live_ptr_b, live_len_a, live_len_b;
  logic [DATA_W-1:0] surf_a, surf_b;
  logic [ST_W-1:0] status;
  logic [ID_W-1:0] mask, ident;
  logic [ROW_W-1:0] row_cnt;
  chp_part_t part;
  logic apply_busy;

  wire wr_status = wr && (addr == OFF_FA_STATUS);
  wire wr_ident = wr && (addr == OFF_FA_IDENT);
  wire run = ctl[CTL_CONTRAST_EN] && ctl[CTL_FAST_ACCESS];
  wire is_b = (part == CHP_PART_B);
  wire [ROW_W-1:0] a_end = live_split[PS_A_END_LSB +: ROW_W];
  wire [ROW_W-1:0] b_end = live_split[PS_B_END_LSB +: ROW_W];
  // Part end when the last zero-based row of the current part completes
  wire part_end = run && row_done &&
    (row_cnt == (is_b ? b_end : a_end));
  wire [1:0] part_sel = is_b ? 2'h2 : 2'h1;
  wire [1:0] hr_set = part_end ? part_sel : 2'h0;
  wire [1:0] hr_clr = wr_status ? wdata[ST_HIST_READY +: 2] : 2'h0;
  wire [1:0] ld_set = wr_status ? wdata[ST_LOAD_TABLE +: 2] : 2'h0;
  wire [1:0] ld_clr = (apply_busy && table_load_done) ?
    (table_part ? 2'h2 : 2'h1) : 2'h0;
  wire [1:0] cd_set = wr_status ? wdata[ST_COPY_DONE +: 2] : 2'h0;
  // Unread histogram at part end, or a table request already pending
  wire late = (|(hr_set & status[ST_HIST_READY +: 2])) ||
    (|(ld_set & status[ST_LOAD_TABLE +: 2]));
  wire [1:0] next_hr = (status[ST_HIST_READY +: 2] & ~hr_clr) | hr_set;
  wire [1:0] next_ld = (status[ST_LOAD_TABLE +: 2] & ~ld_clr) | ld_set;
  wire [ST_W-1:0] next_status = {2'h0, next_ld, next_hr};
  wire [ID_W-1:0] id_set = {late, cd_set, ld_set, hr_set};
  wire [ID_W-1:0] id_clr = wr_ident ? wdata[ID_W-1:0] : {ID_W{1'b0}};
  // Set beats a same-cycle software clear so no event is lost
  wire [ID_W-1:0] next_ident = (ident & ~id_clr) | id_set;
  wire want_a = status[ST_LOAD_TABLE] && !apply_busy;
  wire want_b = status[ST_LOAD_TABLE+1] && !apply_busy;
  wire start_apply = ctl[CTL_APPLY_EN] && (want_a || want_b);

  logic [DATA_W-1:0] next_rdata;
  always_comb begin
    unique case (addr)
      OFF_ENH_CTL: next_rdata = {{(DATA_W-CTL_W){1'b0}}, ctl};
      OFF_PART_SPLIT: next_rdata = part_split;
      OFF_PTR_A: next_rdata = ptr_a;
      OFF_PTR_B: next_rdata = ptr_b;
      OFF_LEN_A: next_rdata = len_a;
      OFF_LEN_B: next_rdata = len_b;
      OFF_LIVE_PTR_A: next_rdata = live_ptr_a;
      OFF_LIVE_PTR_B: next_rdata = live_ptr_b;
      OFF_LIVE_LEN_A: next_rdata = live_len_a;
      OFF_LIVE_LEN_B: next_rdata = live_len_b;
      OFF_FA_STATUS: next_rdata = {{(DATA_W-ST_W){1'b0}}, status};
      OFF_FA_MASK: next_rdata = {{(DATA_W-ID_W){1'b0}}, mask};
      OFF_FA_IDENT: next_rdata = {{(DATA_W-ID_W){1'b0}}, ident};
      OFF_SURF_A: next_rdata = surf_a;
      OFF_SURF_B: next_rdata = surf_b;
      default: next_rdata = WORD_RESET;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl <= CTL_RESET;
      part_split <= WORD_RESET;
      ptr_a <= WORD_RESET;
      ptr_b <= WORD_RESET;
      len_a <= WORD_RESET;
      len_b <= WORD_RESET;
      surf_a <= WORD_RESET;
      surf_b <= WORD_RESET;
      mask <= MASK_RESET;
    end else if (wr) begin
      if (addr == OFF_ENH_CTL) ctl <= wdata[CTL_W-1:0];
      if (addr == OFF_PART_SPLIT) part_split <= wdata;
      if (addr == OFF_PTR_A) ptr_a <= wdata;
      if (addr == OFF_PTR_B) ptr_b <= wdata;
      if (addr == OFF_LEN_A) len_a <= wdata;
      if (addr == OFF_LEN_B) len_b <= wdata;
      if (addr == OFF_SURF_A) surf_a <= wdata;
      if (addr == OFF_SURF_B) surf_b <= wdata;
      if (addr == OFF_FA_MASK) mask <= wdata[ID_W-1:0];
    end
  end

  // Settings take effect at frame start so a frame never mixes two splits
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      live_split <= WORD_RESET;
      live_ptr_a <= WORD_RESET;
      live_ptr_b <= WORD_RESET;
      live_len_a <= WORD_RESET;
      live_len_b <= WORD_RESET;
    end else if (frame_start) begin
      live_split <= part_split;
      live_ptr_a <= ptr_a;
      live_ptr_b <= ptr_b;
      live_len_a <= len_a;
      live_len_b <= len_b;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      row_cnt <= '0;
      part <= CHP_PART_A;
    end else if (frame_start) begin
      row_cnt <= '0;
      part <= CHP_PART_A;
    end else if (run && row_done) begin
      row_cnt <= row_cnt + 8'h01;
      if (part_end) part <= is_b ? CHP_PART_A : CHP_PART_B;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status <= '0;
      ident <= '0;
    end else begin
      status <= next_status;
      ident <= next_ident;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      readout_start <= 1'b0;
      readout_ptr <= WORD_RESET;
      readout_len <= WORD_RESET;
    end else begin
      readout_start <= part_end;
      if (part_end) begin
        readout_ptr <= is_b ? live_ptr_b : live_ptr_a;
        readout_len <= is_b ? live_len_b : live_len_a;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      apply_busy <= 1'b0;
      table_apply <= 1'b0;
      table_part <= 1'b0;
    end else begin
      table_apply <= start_apply;
      if (start_apply) begin
        apply_busy <= 1'b1;
        table_part <= !want_a; // Part A first if both pending
      end else if (table_load_done) begin
        apply_busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= WORD_RESET;
      irq <= 1'b0;
      active_part <= 1'b0;
    end else begin
      rdata <= rd ? next_rdata : WORD_RESET;
      irq <= |(next_ident & ~mask);
      active_part <= (part == CHP_PART_B);
    end
  end

  hr_set_end_a: assert property (@(posedge clk) disable iff (!arst_n)
    part_end && !is_b |=> status[ST_HIST_READY])
    else $error("histogram ready A not set at part end");
  cd_clear_now_a: assert property (@(posedge clk) disable iff (!arst_n)
    status[ST_COPY_DONE +: 2] == 2'h0)
    else $error("copy done status not cleared at once");
  cd_ident_set_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_status && wdata[ST_COPY_DONE] |=> ident[ST_COPY_DONE])
    else $error("copy done identity not latched");
  late_sticky_a: assert property (@(posedge clk) disable iff (!arst_n)
    ident[ID_LATE] && !(wr_ident && wdata[ID_LATE]) |=> ident[ID_LATE])
    else $error("late identity bit dropped");
  irq_mask_a: assert property (@(posedge clk) disable iff (!arst_n)
    ##1 irq == |($past(next_ident) & ~$past(mask)))
    else $error("interrupt does not follow unmasked identity");
  part_alt_a: assert property (@(posedge clk) disable iff (!arst_n)
    part_end && !frame_start |=> part != $past(part))
    else $error("part did not alternate at part end");
  readout_len_a: assert property (@(posedge clk) disable iff (!arst_n)
    part_end && is_b |=> readout_start && readout_len == $past(live_len_b))
    else $error("readout length not taken from part B");
  apply_pulse_a: assert property (@(posedge clk) disable iff (!arst_n)
    table_apply |-> ctl[CTL_APPLY_EN] || $past(ctl[CTL_APPLY_EN]))
    else $error("table applied while application off");
  ld_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    status[ST_LOAD_TABLE] && !(apply_busy && table_load_done && !table_part)
      |=> status[ST_LOAD_TABLE])
    else $error("load table A cleared before load completed");
  first_part_a: assert property (@(posedge clk) disable iff (!arst_n)
    frame_start |=> part == CHP_PART_A && row_cnt == 8'h00)
    else $error("frame did not restart in part A");
endmodule : chp_part_handoff
`default_nettype wire

/* verif/chp_far_model.sv */
`timescale 1ns/100ps
`default_nettype none
module chp_far_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic table_apply,
  input wire logic [3:0] load_lat,
  output logic table_load_done
);
  logic [4:0] wait_cnt;

  // Loading ends load_lat + 2 cycles after apply; zero gives a prompt engine
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_cnt <= 5'h00;
      table_load_done <= 1'b0;
    end else begin
      table_load_done <= (wait_cnt == 5'h01);
      if (table_apply) begin
        wait_cnt <= {1'b0, load_lat} + 5'h01;
      end else if (wait_cnt != 5'h00) begin
        wait_cnt <= wait_cnt - 5'h01;
      end
    end
  end
endmodule : chp_far_model
`default_nettype wire

/* verif/tb_chp_part_handoff.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_chp_part_handoff;
  import chp_pkg::*;
  logic clk, arst_n, wr, rd, frame_start, row_done, table_load_done;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, readout_ptr, readout_len, len_a, len_b;
  logic readout_start, table_apply, table_part, active_part, irq;
  logic [3:0] load_lat;
  int bad_count, comparisons;
  logic [31:0] exp_q[$];
  localparam int TILE = 256;
  localparam int DW_PER_TILE = 16; // Arbitrary, fixed by the table format
  int src_w, src_h, cols, a_end, b_end, a_rows, b_rows, ie_words;
  logic [31:0] split, ptr_b;

  chp_part_handoff chp_part_handoff_i (.clk(clk), .arst_n(arst_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .frame_start(frame_start), .row_done(row_done),
    .table_load_done(table_load_done), .readout_start(readout_start),
    .readout_ptr(readout_ptr), .readout_len(readout_len),
    .table_apply(table_apply), .table_part(table_part),
    .active_part(active_part), .irq(irq));
  chp_far_model chp_far_model_i (.clk(clk), .arst_n(arst_n),
    .table_apply(table_apply), .load_lat(load_lat),
    .table_load_done(table_load_done));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input string what);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(what, rdata, exp);
  endtask : rd_chk

  task automatic pulse(input bit is_row);
    @(posedge clk);
    if (is_row) row_done <= 1'b1;
    else frame_start <= 1'b1;
    @(posedge clk);
    row_done <= 1'b0;
    frame_start <= 1'b0;
  endtask : pulse

  // Rows of one part, then the readout must start from the queued model
  task automatic run_part(input int rows, input logic exp_part);
    int n;
    repeat (rows) pulse(1'b1);
    // Readout pulse is launched at this very edge; look once it has settled
    #1;
    for (n = 0; n < 4 && readout_start !== 1'b1; n++) @(posedge clk) #1;
    chk("readout_start", {31'h0, readout_start}, 32'h1);
    chk("readout_ptr", readout_ptr, exp_q.pop_front());
    chk("readout_len", readout_len, exp_q.pop_front());
    @(posedge clk) #1;
    chk("active_part", {31'h0, active_part}, {31'h0, exp_part});
  endtask : run_part

  task automatic test_done;
    if (bad_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    test_done();
  end

  initial begin
    {wr, rd, frame_start, row_done, arst_n} = 5'h00;
    addr = 8'h00;
    wdata = 32'h0;
    load_lat = 4'h0;
    bad_count = 0;
    comparisons = 0;
    void'($urandom(32'h4d6b));
    src_w = $urandom_range(5120, 1);
    // Heights here keep both parts at three tile rows or more
    src_h = $urandom_range(2560, 1537);
    cols = (src_w + TILE - 1) / TILE;
    a_end = src_h / 2 / TILE + 1;
    b_end = (src_h + TILE - 1) / TILE;
    a_rows = a_end;
    b_rows = b_end - a_end;
    len_a = a_rows * cols * DW_PER_TILE;
    len_b = b_rows * cols * DW_PER_TILE;
    ie_words = (a_rows - 1) * cols * DW_PER_TILE;
    split = {8'(b_end - 1), 8'(a_end), 8'(a_end - 1), 8'h00};
    ptr_b = {8'h00, 8'(a_end + 1), 16'h0000};
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    rd_chk(OFF_ENH_CTL, 32'h0, "ctl reset");
    rd_chk(OFF_FA_MASK, 32'h7f, "mask reset");
    rd_chk(8'hfc, 32'h0, "unmapped read");
    wr_reg(OFF_ENH_CTL, 32'h3);
    wr_reg(OFF_PART_SPLIT, split);
    wr_reg(OFF_PTR_A, 32'h0);
    wr_reg(OFF_PTR_B, ptr_b);
    wr_reg(OFF_LEN_A, len_a);
    wr_reg(OFF_LEN_B, len_b);
    wr_reg(OFF_FA_MASK, 32'h4f);
    exp_q = '{32'h0, len_a, ptr_b, len_b, 32'h0, len_a};
    pulse(1'b0);
    rd_chk(OFF_LIVE_LEN_B, len_b, "live len");
    rd_chk(OFF_LIVE_PTR_B, ptr_b, "live ptr");
    run_part(a_rows, 1'b1);
    rd_chk(OFF_FA_STATUS, 32'h1, "ready A");
    wr_reg(OFF_FA_STATUS, 32'h11);
    rd_chk(OFF_FA_STATUS, 32'h0, "copy A cleared");
    rd_chk(OFF_FA_IDENT, 32'h11, "ident A");
    chk("irq A", {31'h0, irq}, 32'h1);
    wr_reg(OFF_FA_IDENT, 32'h7f);
    run_part(b_rows, 1'b0);
    rd_chk(OFF_FA_STATUS, 32'h2, "ready B");
    wr_reg(OFF_FA_STATUS, 32'h22);
    rd_chk(OFF_FA_IDENT, 32'h22, "ident B");
    wr_reg(OFF_FA_IDENT, 32'h7f);
    // Load bit written twice before apply is the overlap error
    wr_reg(OFF_FA_STATUS, 32'h4);
    wr_reg(OFF_FA_STATUS, 32'h4);
    rd_chk(OFF_FA_IDENT, 32'h44, "late ident");
    chk("irq masked", {31'h0, irq}, 32'h0);
    // Load time is the table size modulo 8, always zero here since the size is a multiple of 16 words
    load_lat <= 4'(ie_words % 8);
    wr_reg(OFF_ENH_CTL, 32'h7);
    for (int n = 0; n < 6 && table_apply !== 1'b1; n++) @(posedge clk) #1;
    chk("table_apply", {31'h0, table_apply}, 32'h1);
    chk("table_part", {31'h0, table_part}, 32'h0);
    repeat (12) @(posedge clk);
    rd_chk(OFF_FA_STATUS, 32'h0, "load cleared");
    rd_chk(OFF_FA_IDENT, 32'h44, "late sticky");
    // A fresh frame reaches part B, then the next frame restarts in A
    pulse(1'b0);
    run_part(a_rows, 1'b1);
    pulse(1'b0);
    repeat (2) @(posedge clk) #1;
    chk("part back to A", {31'h0, active_part}, 32'h0);
    test_done();
  end
endmodule : tb_chp_part_handoff
`default_nettype wire
